// *** hdl/camctr_top.sv ***
// Purpose: two-channel electronic cam counter with APB register file
// Assumes: pclk 10 MHz, encoder and marker pins asynchronous to pclk
// Notes:   stored configuration is a static strap vector sampled at runtime
//
// Chosen here: the APB slave port and the register offsets.
`include "camctr_regs.svh"

module camctr_top #(
  parameter logic [15:0] OPTION_ID = 16'h00a5   // arbitrary identity value
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // stored configuration image (same layout as the output vector)
  input  wire logic [40:0] stored_cfg,
  // encoder and general inputs
  input  wire logic [7:0]  din_pins,
  input  wire logic        enc_a_a,
  input  wire logic        enc_a_b,
  input  wire logic        enc_a_marker,
  input  wire logic        enc_b_a,
  input  wire logic        enc_b_b,
  input  wire logic        enc_b_marker,
  // output pins and input conditioning controls
  output logic [7:0]       dout_pins,
  output logic [1:0]       vin_thresh_sel,
  output logic [1:0]       in_filter_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    camctr_pkg::camctr_apb_st_t st;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    logic [40:0]                outv;      // host written outputs and config
    camctr_pkg::camctr_word_t [15:0] setpt;
    camctr_pkg::camctr_word_t [1:0]  rev;
    camctr_pkg::camctr_word_t [1:0]  cnt;
    logic [1:0][2:0]            qa;        // sync chains
    logic [1:0][2:0]            qb;
    logic [1:0][2:0]            mk;
    logic [7:0][2:0]            din_s;
    logic [1:0]                 a_prev;
    logic [1:0]                 b_prev;
    logic [1:0]                 mk_prev;
    logic [3:0]                 tick_cnt;
    logic [2:0][3:0]            dec_cnt;
    logic [7:0]                 dout;
    logic [1:0]                 vin;
    logic [1:0]                 filt;
  } camctr_state_t;

  camctr_state_t s_q;
  camctr_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // cam window test with wrap when low exceeds high
  function automatic logic cam_on(input logic [15:0] pos, input logic [15:0] lo, input logic [15:0] hi);
    if (lo <= hi)
      cam_on = (pos >= lo) && (pos < hi);
    else
      cam_on = (pos >= lo) || (pos < hi);
  endfunction

  // decade counter step: returns wrap flag
  function automatic logic dec_wrap(input logic [3:0] v);
    dec_wrap = (v == 4'(`CAMCTR_DECADE - 1));
  endfunction

  // effective config: stored image unless override mask is set
  logic [40:0] cfg;
  always_comb
  begin
    cfg = s_q.outv[`CAMCTR_B_MASK] ? s_q.outv : stored_cfg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic [2:0] tick_en;          // 100k, 10k, 1k enables
  logic       tick_1m;
  logic [7:0] cam;
  logic [7:0] pin;
  logic [11:0] sidx;
  logic        hit;

  always_comb
  begin
    s_d = s_q;
    sidx = 12'h000;
    hit = 1'b0;
    // three-stage synchronisers, only stages 2 and 3 compared
    for (int c = 0; c < 2; c++)
    begin
      s_d.qa[c] = {s_q.qa[c][1:0], (c == 0) ? enc_a_a : enc_b_a};
      s_d.qb[c] = {s_q.qb[c][1:0], (c == 0) ? enc_a_b : enc_b_b};
      s_d.mk[c] = {s_q.mk[c][1:0], (c == 0) ? enc_a_marker : enc_b_marker};
    end
    for (int i = 0; i < 8; i++)
      s_d.din_s[i] = {s_q.din_s[i][1:0], din_pins[i]};

    // internal clock divider chain
    tick_1m = (s_q.tick_cnt == 4'(`CAMCTR_TICK_DIV - 1));
    s_d.tick_cnt = tick_1m ? 4'h0 : s_q.tick_cnt + 4'h1;
    tick_en[0] = tick_1m && dec_wrap(s_q.dec_cnt[0]);
    tick_en[1] = tick_en[0] && dec_wrap(s_q.dec_cnt[1]);
    tick_en[2] = tick_en[1] && dec_wrap(s_q.dec_cnt[2]);
    if (tick_1m)
      s_d.dec_cnt[0] = dec_wrap(s_q.dec_cnt[0]) ? 4'h0 : s_q.dec_cnt[0] + 4'h1;
    if (tick_en[0])
      s_d.dec_cnt[1] = dec_wrap(s_q.dec_cnt[1]) ? 4'h0 : s_q.dec_cnt[1] + 4'h1;
    if (tick_en[1])
      s_d.dec_cnt[2] = dec_wrap(s_q.dec_cnt[2]) ? 4'h0 : s_q.dec_cnt[2] + 4'h1;

    // counters per channel
    for (int c = 0; c < 2; c++)
    begin
      logic a_n;
      logic b_n;
      logic mk_n;
      logic mk_act;
      logic mk_edge;
      logic step;
      logic up;
      logic [1:0] ps;
      logic [15:0] nxt;
      logic [15:0] rev;
      a_n = 1'b0;
      b_n = 1'b0;
      mk_n = 1'b0;
      mk_act = 1'b0;
      mk_edge = 1'b0;
      step = 1'b0;
      up = 1'b1;
      ps = 2'b00;
      nxt = s_q.cnt[c];
      rev = s_q.rev[c];
      // filtered levels: second and third stage agree
      a_n = (s_q.qa[c][1] == s_q.qa[c][2]) ? s_q.qa[c][2] : s_q.a_prev[c];
      b_n = (s_q.qb[c][1] == s_q.qb[c][2]) ? s_q.qb[c][2] : s_q.b_prev[c];
      mk_n = (s_q.mk[c][1] == s_q.mk[c][2]) ? s_q.mk[c][2] : s_q.mk_prev[c];
      s_d.a_prev[c] = a_n;
      s_d.b_prev[c] = b_n;
      s_d.mk_prev[c] = mk_n;
      // marker polarity and phase qualification
      mk_act = mk_n ^ cfg[(c == 0) ? `CAMCTR_B_MPOLA : `CAMCTR_B_MPOLB];
      mk_edge = mk_act && !(s_q.mk_prev[c] ^ cfg[(c == 0) ? `CAMCTR_B_MPOLA : `CAMCTR_B_MPOLB])
                && (b_n == !cfg[(c == 0) ? `CAMCTR_B_MPHSA : `CAMCTR_B_MPHSB]);
      ps = (c == 0) ? cfg[`CAMCTR_B_PSA +: 2] : cfg[`CAMCTR_B_PSB +: 2];
      if (cfg[(c == 0) ? `CAMCTR_B_CLKA : `CAMCTR_B_CLKB])
      begin
        // internal clock, forced up count, rate from prescaler bits
        step = (ps == 2'b00) ? tick_1m : tick_en[ps - 2'b01];
        up = 1'b1;
      end
      else if (a_n != s_q.a_prev[c] || b_n != s_q.b_prev[c])
      begin
        // x4 quadrature decode
        step = 1'b1;
        up = (a_n ^ s_q.b_prev[c]);
      end
      if (step)
        nxt = up ? s_q.cnt[c] + 16'h0001 : s_q.cnt[c] - 16'h0001;
      // wrap at counts per revolution
      if (rev != 16'h0000 && step && up && nxt >= rev)
        nxt = 16'h0000;
      else if (rev != 16'h0000 && step && !up && s_q.cnt[c] == 16'h0000)
        nxt = rev - 16'h0001;
      if (mk_edge || s_q.outv[(c == 0) ? `CAMCTR_B_RSTA : `CAMCTR_B_RSTB])
        nxt = 16'h0000;
      s_d.cnt[c] = nxt;
    end

    // cam signals: 1-4 on channel a, 5-8 on channel b
    for (int k = 0; k < 8; k++)
      cam[k] = cam_on(s_q.cnt[k / 4], s_q.setpt[2 * k], s_q.setpt[2 * k + 1])
               ^ cfg[`CAMCTR_B_INV + k];
    // merge tree: 1->2, 2->4, 3->4, 4->8, 5->6, 6->8, 7->8
    begin
      logic [7:0] m;
      logic [7:0] acc;
      m = {1'b0, cfg[`CAMCTR_B_MRG +: 7]};
      acc = cam;
      acc[1] = acc[1] | (m[0] & acc[0]);
      acc[3] = acc[3] | (m[1] & acc[1]) | (m[2] & acc[2]);
      acc[5] = acc[5] | (m[4] & acc[4]);
      acc[7] = acc[7] | (m[3] & acc[3]) | (m[5] & acc[5]) | (m[6] & acc[6]);
      for (int k = 0; k < 7; k++)
        pin[k] = m[k] ? s_q.outv[k] : acc[k];
      pin[7] = acc[7];
    end
    s_d.dout = pin;
    s_d.vin = cfg[`CAMCTR_B_VIN +: 2];
    s_d.filt = cfg[`CAMCTR_B_FILT +: 2];

    // apb: setup takes us to access, answer one cycle later
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    case (s_q.st)
      camctr_pkg::camctr_idle:
      begin
        if (psel && !penable)
          s_d.st = camctr_pkg::camctr_access;
      end
      camctr_pkg::camctr_access:
      begin
        if (s_q.pready)
        begin
          s_d.st = camctr_pkg::camctr_idle;
        end
        else
        begin
          s_d.pready = 1'b1;
          s_d.prdata = 32'h0000_0000;
          hit = 1'b1;
          sidx = (paddr - `CAMCTR_OFS_SETPT) >> 2;
          if (paddr[1:0] != 2'b00)
            hit = 1'b0;
          else if (paddr == `CAMCTR_OFS_INPUTS)
          begin
            for (int i = 0; i < 8; i++)
              s_d.prdata[i] = s_q.din_s[i][2];
          end
          else if (paddr == `CAMCTR_OFS_OUTLO)
          begin
            s_d.prdata = s_q.outv[31:0];
            if (pwrite)
              s_d.outv = (s_q.outv & `CAMCTR_CFG_MASK) | ({9'h000, pwdata} & ~`CAMCTR_CFG_MASK);
            // once the mask was set, all config bits follow writes
            if (pwrite && (s_q.outv[`CAMCTR_B_MASK] || pwdata[`CAMCTR_B_MASK]))
              s_d.outv[31:0] = pwdata;
          end
          else if (paddr == `CAMCTR_OFS_OUTHI)
          begin
            s_d.prdata = {23'h000000, s_q.outv[40:32]};
            if (pwrite && s_q.outv[`CAMCTR_B_MASK])
              s_d.outv[40:32] = pwdata[8:0];
          end
          else if (paddr == `CAMCTR_OFS_IDENT)
            s_d.prdata = {16'h0000, OPTION_ID};
          else if (paddr == `CAMCTR_OFS_CNTA)
            s_d.prdata = {16'h0000, s_q.cnt[0]};
          else if (paddr == `CAMCTR_OFS_CNTB)
            s_d.prdata = {16'h0000, s_q.cnt[1]};
          else if (paddr >= `CAMCTR_OFS_SETPT && paddr <= `CAMCTR_OFS_SETPT_END)
          begin
            s_d.prdata = {16'h0000, s_q.setpt[sidx[3:0]]};
            if (pwrite)
              s_d.setpt[sidx[3:0]] = pwdata[15:0];
          end
          else if (paddr == `CAMCTR_OFS_REVA || paddr == `CAMCTR_OFS_REVB)
          begin
            s_d.prdata = {16'h0000, s_q.rev[paddr[2]]};
            if (pwrite)
              s_d.rev[paddr[2]] = pwdata[15:0];
          end
          else
            hit = 1'b0;
          s_d.pslverr = !hit;
        end
      end
      default:
        s_d.st = camctr_pkg::camctr_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // all state resets to zero, so stored image governs until overridden
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // outputs straight from flip-flops
  assign pready         = s_q.pready;
  assign prdata         = s_q.prdata;
  assign pslverr        = s_q.pslverr;
  assign dout_pins      = s_q.dout;
  assign vin_thresh_sel = s_q.vin;
  assign in_filter_sel  = s_q.filt;

endmodule

// *** hdl/camctr_regs.svh ***
// Purpose: register map, field positions and timing constants of the cam counter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   the stored configuration arrives as a static input vector
`ifndef CAMCTR_REGS_SVH
`define CAMCTR_REGS_SVH

// register byte offsets
`define CAMCTR_OFS_INPUTS    12'h000
`define CAMCTR_OFS_OUTLO     12'h004
`define CAMCTR_OFS_OUTHI     12'h008
`define CAMCTR_OFS_IDENT     12'h00c
`define CAMCTR_OFS_CNTA      12'h010
`define CAMCTR_OFS_CNTB      12'h014
`define CAMCTR_OFS_SETPT     12'h020
`define CAMCTR_OFS_SETPT_END 12'h05c
`define CAMCTR_OFS_REVA      12'h060
`define CAMCTR_OFS_REVB      12'h064

// bit positions inside the 41-bit output and configuration vector (bit 0 = first)
`define CAMCTR_B_MASK   7
`define CAMCTR_B_MRG    8
`define CAMCTR_B_MPOLA  16
`define CAMCTR_B_MPHSA  17
`define CAMCTR_B_CLKA   18
`define CAMCTR_B_RSTA   19
`define CAMCTR_B_MPOLB  20
`define CAMCTR_B_MPHSB  21
`define CAMCTR_B_CLKB   22
`define CAMCTR_B_RSTB   23
`define CAMCTR_B_INV    24
`define CAMCTR_B_VIN    32
`define CAMCTR_B_FILT   34
`define CAMCTR_B_PSA    36
`define CAMCTR_B_PSB    38
// bits that only change while the override mask is set
`define CAMCTR_CFG_MASK 41'h1ff_ff77_ff00
`define CAMCTR_OUTHI_MASK 32'h0000_01ff

// internal clock: 1 MHz from the 10 MHz pclk, then decades
`define CAMCTR_PCLK_HZ  10000000
`define CAMCTR_TICK_HZ  1000000
`define CAMCTR_TICK_DIV (`CAMCTR_PCLK_HZ / `CAMCTR_TICK_HZ)
`define CAMCTR_DECADE   10

`endif

// *** hdl/camctr_pkg.sv ***
// Purpose: types shared by the cam counter
// Assumes: nothing
// Notes:   constants live in camctr_regs.svh
package camctr_pkg;
  typedef enum logic [1:0] {camctr_idle, camctr_access} camctr_apb_st_t;
  typedef logic [15:0] camctr_word_t;
endpackage

// *** testbench/camctr_sva.sv ***
// Purpose: bus and configuration checks at the cam counter ports
// Assumes: stored_cfg static, one bus master
// Notes:   helper flops mirror the override mask and last override word
`include "camctr_regs.svh"
module camctr_sva #(
  parameter logic [15:0] OPTION_ID = 16'h00a5
) (
  // bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // configuration
  input wire logic [40:0] stored_cfg,
  input wire logic [1:0]  vin_thresh_sel,
  input wire logic [1:0]  in_filter_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ovr_q;
  logic       seen_q;
  logic [1:0] calm_q;
  logic [3:0] hi_q;
  wire        wr_lo = pready && pwrite && paddr == `CAMCTR_OFS_OUTLO;
  wire        wr_hi = pready && pwrite && paddr == `CAMCTR_OFS_OUTHI;
  wire        bad   = paddr[1:0] != 2'h0 || paddr > `CAMCTR_OFS_REVB ||
                      (paddr > `CAMCTR_OFS_CNTB && paddr < `CAMCTR_OFS_SETPT);
  ////////////////////
  // calm_q waits out the register stages after a config write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {ovr_q, seen_q, calm_q, hi_q} <= '0;
    else
    begin
      ovr_q  <= wr_lo ? pwdata[7] : ovr_q;
      seen_q <= seen_q | (wr_hi & ovr_q);
      hi_q   <= (wr_hi && ovr_q) ? pwdata[3:0] : hi_q;
      calm_q <= (wr_lo || wr_hi) ? 2'h0 : calm_q + {1'b0, calm_q != 2'h3};
    end
  ////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("no answer one wait after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable, 2))
    else $error("ready without a transfer");
  a_err_bad: assert property (pready && bad |-> pslverr)
    else $error("unmapped access not flagged");
  a_err_good: assert property (pready && !bad |-> !pslverr)
    else $error("mapped access flagged");
  a_ident_word: assert property (pready && !pwrite && paddr == `CAMCTR_OFS_IDENT
    |-> prdata[15:0] == OPTION_ID) else $error("identity word wrong");
  a_stored_cfg: assert property (calm_q == 2'h3 && !ovr_q
    |-> {in_filter_sel, vin_thresh_sel} == stored_cfg[35:32]) else $error("stored setup not in use");
  a_ovr_cfg: assert property (calm_q == 2'h3 && ovr_q && seen_q
    |-> {in_filter_sel, vin_thresh_sel} == hi_q) else $error("override setup not in use");
  c_err: cover property (pready && pslverr);
  c_ovr: cover property (calm_q == 2'h3 && ovr_q && seen_q);
  c_back: cover property (pready ##1 psel && !penable);
endmodule

bind camctr_top camctr_sva #(.OPTION_ID(OPTION_ID)) u_camctr_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .stored_cfg(stored_cfg),
  .vin_thresh_sel(vin_thresh_sel), .in_filter_sel(in_filter_sel));

// *** testbench/camctr_enc_model.sv ***
// Purpose: quadrature encoder stand-in for counter channel a
// Assumes: one step per fwd or rev pulse
// Notes:   gray order, so one line moves per step
module camctr_enc_model (
  // step requests
  input wire logic pclk,
  input wire logic fwd,
  input wire logic rev,
  // encoder lines
  output logic     qa,
  output logic     qb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase_q = 2'h0;
  // forward adds one, reverse adds three (minus one)
  always_ff @(posedge pclk)
    phase_q <= phase_q + {rev, fwd | rev};
  assign qa = phase_q[1];
  assign qb = phase_q[1] ^ phase_q[0];
endmodule

// *** testbench/camctr_top_bench.sv ***
// Purpose: self-checking bench for the cam counter
// Assumes: stored setup static for the run
// Notes:   counts are judged by direction and rate, not decode factor
`include "camctr_regs.svh"
module camctr_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ID = 16'h3c5a; // arbitrary identity value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, qa, qb, mark, fwd, rev, e;
  logic [11:0] paddr;
  logic [11:0] bad [3] = '{12'h018, 12'h068, 12'h022};
  logic [31:0] pwdata, prdata, r, c0;
  logic [40:0] scfg;
  logic [7:0]  din, dout, v;
  logic [5:0]  hv;
  logic [1:0]  vin, filt;
  int          failures, check_count, seed, d;
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  camctr_top #(.OPTION_ID(ID)) u_camctr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stored_cfg(scfg), .din_pins(din), .enc_a_a(qa), .enc_a_b(qb), .enc_a_marker(mark), .enc_b_a(1'b0),
    .enc_b_b(1'b0), .enc_b_marker(1'b0), .dout_pins(dout), .vin_thresh_sel(vin), .in_filter_sel(filt));
  camctr_enc_model u_camctr_enc_model (.pclk(pclk), .fwd(fwd), .rev(rev), .qa(qa), .qb(qb));
  ////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer; an idle edge after release keeps strobes apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, dat};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1)
    begin
      failures++;
      complete_run();
    end
    @(posedge pclk);
  endtask
  task automatic step(input logic dir, input int k);
    repeat (k)
    begin
      {fwd, rev} <= {dir, ~dir};
      @(posedge pclk);
      {fwd, rev} <= 2'b00;
      repeat (8) @(posedge pclk);
    end
  endtask
  // internal clock ticks seen in cyc pclk cycles at prescale ps
  function automatic int ticks(input int cyc, input int ps);
    return cyc / (10 * (10 ** ps));
  endfunction
  task automatic complete_run();
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////
  initial
  begin
    {seed, failures, check_count} = {32'h7911, 64'h0};
    {presetn, psel, penable, pwrite, fwd, rev, mark, paddr, pwdata} = '0;
    din = 8'($random(seed));
    scfg = 41'({$random(seed), $random(seed)}) & ~41'h80;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CAMCTR_OFS_IDENT, 32'h0);
    chk({16'h0, r[15:0]}, {16'h0, ID});
    foreach (bad[i])
    begin
      apb(1'b0, bad[i], 32'h0);
      chk({31'h0, e}, 32'h1);
    end
    din <= 8'($random(seed));
    repeat (5) @(posedge pclk);
    apb(1'b0, `CAMCTR_OFS_INPUTS, 32'h0);
    chk(r, {24'h0, din});
    // config word written with the mask clear must be ignored
    apb(1'b1, `CAMCTR_OFS_OUTHI, 32'($random(seed)));
    repeat (4) @(posedge pclk);
    chk({28'h0, filt, vin}, {28'h0, scfg[35:32]});
    for (int a = 32; a <= 100; a += 4)
    begin
      v = 8'($random(seed));
      apb(1'b1, 12'(a), {16'h0, v, ~v});
      apb(1'b0, 12'(a), 32'h0);
      chk({16'h0, r[15:0]}, {16'h0, v, ~v});
      apb(1'b1, 12'(a), 32'h0);
    end
    // mask set, all merges on: pins one to seven become plain outputs
    {v, hv} = 14'($random(seed));
    apb(1'b1, `CAMCTR_OFS_OUTLO, {16'h0, 8'h7f, 1'b1, v[6:0]});
    apb(1'b1, `CAMCTR_OFS_OUTHI, {26'h0, hv});
    repeat (4) @(posedge pclk);
    chk({28'h0, filt, vin}, {28'h0, hv[3:0]});
    chk({24'h0, dout}, {25'h0, v[6:0]});
    apb(1'b1, `CAMCTR_OFS_OUTLO, {v, 24'h80});
    repeat (4) @(posedge pclk);
    chk({24'h0, dout}, {24'h0, v});
    apb(1'b1, `CAMCTR_OFS_OUTLO, 32'h80);
    apb(1'b0, `CAMCTR_OFS_CNTA, 32'h0);
    c0 = r;
    step(1'b1, 6);
    apb(1'b0, `CAMCTR_OFS_CNTA, 32'h0);
    chk({31'h0, r !== c0}, 32'h1);
    step(1'b0, 6);
    apb(1'b0, `CAMCTR_OFS_CNTA, 32'h0);
    chk(r, c0);
    // cam window just around the standing count, then just past it
    apb(1'b1, `CAMCTR_OFS_SETPT, {16'h0, c0[15:0]});
    apb(1'b1, `CAMCTR_OFS_SETPT + 12'h4, {16'h0, c0[15:0] + 16'h1});
    repeat (4) @(posedge pclk);
    chk({31'h0, dout[0]}, 32'h1);
    apb(1'b1, `CAMCTR_OFS_SETPT, {16'h0, c0[15:0] + 16'h1});
    repeat (4) @(posedge pclk);
    chk({31'h0, dout[0]}, 32'h0);
    // marker clears the count, first active high then active low
    step(1'b1, 2);
    mark <= 1'b1;
    repeat (4) @(posedge pclk);
    mark <= 1'b0;
    apb(1'b0, `CAMCTR_OFS_CNTA, 32'h0);
    chk(r, 32'h0);
    mark <= 1'b1;
    apb(1'b1, `CAMCTR_OFS_OUTLO, 32'h0001_0080);
    step(1'b1, 4);
    apb(1'b0, `CAMCTR_OFS_CNTA, 32'h0);
    chk({31'h0, r !== 32'h0}, 32'h1);
    mark <= 1'b0;
    // marker needs the synchroniser stages before it clears the count
    repeat (5) @(posedge pclk);
    apb(1'b0, `CAMCTR_OFS_CNTA, 32'h0);
    chk(r, 32'h0);
    // channel b on the internal clock at two prescales
    apb(1'b1, `CAMCTR_OFS_OUTLO, 32'h0040_0080);
    for (int ps = 0; ps < 2; ps++)
    begin
      apb(1'b1, `CAMCTR_OFS_OUTHI, {24'h0, 2'(ps), 6'h0});
      apb(1'b0, `CAMCTR_OFS_CNTB, 32'h0);
      c0 = r;
      repeat (400) @(posedge pclk);
      apb(1'b0, `CAMCTR_OFS_CNTB, 32'h0);
      d = int'(r[15:0] - c0[15:0]) - ticks(404, ps);
      chk({31'h0, d >= -1 && d <= 1}, 32'h1);
    end
    // reset in mid-run drops the override, stored setup governs again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({28'h0, filt, vin}, {28'h0, scfg[35:32]});
    apb(1'b0, `CAMCTR_OFS_OUTLO, 32'h0);
    chk(r, 32'h0);
    complete_run();
  end
endmodule
